/* hdl/reset_gen_and_pll_test_mux.sv */
// Reset generator, per-module reset matrix and PLL test-mode pin routing
`timescale 1ns/1ps
`default_nettype none
module reset_gen_and_pll_test_mux
  import rst_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic por_pulse,
  input wire logic ext_reset_n,
  input wire logic wdog_enable,
  input wire logic wdog_expire,
  input wire logic wdog_serviced,
  input wire logic host_iface_rst_bit,
  input wire logic sw_service_write,
  input wire logic pll_bypass_test_n,
  input wire logic selftest_enable_n,
  input wire logic osc_input_pin,
  input wire logic [13:0] port_a_in,
  input wire logic tck_in,
  input wire logic td1_in,
  input wire logic [1:0] fw_indiv,
  input wire logic [3:0] fw_icp,
  input wire logic [1:0] fw_outdiv,
  input wire logic [3:0] fw_poltst,
  input wire logic pll_divider_out,
  input wire logic pll_pump_up,
  input wire logic pll_lock,
  input wire logic pll_pump_down,
  input wire logic pll_clock_out,
  output logic hw_reset,
  output logic rst_core,
  output logic rst_eth_front_end,
  output logic rst_dma,
  output logic rst_general_module,
  output logic rst_serial_module,
  output logic rst_embedded_host_iface,
  output logic rst_mem_ctrl,
  output logic rst_general_sticky_fields,
  output logic port_c_bit4_out,
  output logic osc_on,
  output logic core_clock_sel_osc,
  output logic [1:0] pll_indiv,
  output logic [3:0] pll_icp,
  output logic [1:0] pll_outdiv,
  output logic [3:0] pll_poltst,
  output logic pll_disable,
  output logic pll_test,
  output logic pll_ref_clk,
  output logic pll_fb_clk,
  output logic [4:0] port_a_obs_out,
  output logic [4:0] port_a_obs_oe
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOLD
  } hold_state_t;

  typedef struct packed {
    logic [DEGLITCH_STAGES-1:0] dg;
    logic ext_armed;
    hold_state_t st;
    logic [HOLD_W-1:0] hold_cnt;
    logic hw_rst;
    logic wd_rst;
    logic sw_rst;
    logic host_rst;
    logic core;
    logic eth;
    logic dma;
    logic gen;
    logic serial_module;
    logic hif;
    logic mem;
    logic gen_sticky;
    logic pc4;
    logic osc_on;
    logic clk_sel;
    logic [1:0] indiv;
    logic [3:0] icp;
    logic [1:0] outdiv;
    logic [3:0] poltst;
    logic dis;
    logic tst;
    logic ckr;
    logic ckdiv;
    logic [4:0] obs;
    logic [4:0] obs_oe;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [POR_CNT_W-1:0] por_cnt_q;
  logic por_trig_q;
  logic ext_lvl;
  logic test_lvl;
  logic bist_lvl;

  // Power-on counter: async clear is a constant so the pad pulse never
  // reaches a data input; the trigger pulses once at the terminal count
  always_ff @(posedge clk_sys or posedge por_pulse) begin
    if (por_pulse) begin
      por_cnt_q <= POR_CNT_RST;
      por_trig_q <= 1'b0;
    end else if (por_cnt_q != POR_CNT_DONE) begin
      por_cnt_q <= por_cnt_q + 5'h01;
      por_trig_q <= (por_cnt_q == POR_CNT_DONE - 5'h01);
    end else begin
      por_trig_q <= 1'b0;
    end
  end

  // Pins from outside the clock domain
  pin_sync #(.RST_VAL(1'b1)) u_sync_ext (
    .clk_sys(clk_sys), .rstn(rstn), .pin(ext_reset_n), .level(ext_lvl)
  );
  pin_sync #(.RST_VAL(1'b1)) u_sync_test (
    .clk_sys(clk_sys), .rstn(rstn), .pin(pll_bypass_test_n), .level(test_lvl)
  );
  pin_sync #(.RST_VAL(1'b1)) u_sync_bist (
    .clk_sys(clk_sys), .rstn(rstn), .pin(selftest_enable_n), .level(bist_lvl)
  );

  // Tester and PLL lines also come from outside the clock domain; each bit
  // has its own synchroniser, so a multi-bit field may show a mixed value
  // for one cycle while it changes. The tester holds its levels steady, and
  // the observation bits are only passed on, never decoded.
  localparam int ASYNC_N = 21;
  logic [ASYNC_N-1:0] async_raw;
  logic [ASYNC_N-1:0] async_lvl;
  logic [13:0] pa_lvl;
  logic tck_lvl;
  logic td1_lvl;
  logic [4:0] obs_lvl;

  // Raw lines gathered; observation bits on top, port A at the bottom
  assign async_raw = {
    pll_clock_out,
    pll_pump_down,
    pll_lock,
    pll_pump_up,
    pll_divider_out,
    td1_in,
    tck_in,
    port_a_in
  };
  assign pa_lvl = async_lvl[13:0];
  assign tck_lvl = async_lvl[14];
  assign td1_lvl = async_lvl[15];
  assign obs_lvl = async_lvl[20:16];

  // One three-stage synchroniser per line, idle low out of reset
  for (genvar i = 0; i < ASYNC_N; i++) begin : g_sync
    pin_sync #(.RST_VAL(1'b0)) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .pin(async_raw[i]),
      .level(async_lvl[i])
    );
  end

  always_comb begin
    logic ext_trig;
    logic hw_any;
    ext_trig = 1'b0;
    hw_any = 1'b0;
    s_d = s_q;
    // Deglitch chain: a low seen in every stage arms the trigger,
    // which fires once every stage is back high
    s_d.dg = {s_q.dg[DEGLITCH_STAGES-2:0], ext_lvl};
    if (s_q.dg == '0) begin
      s_d.ext_armed = 1'b1;
    end else if (s_q.ext_armed && (s_q.dg == '1)) begin
      s_d.ext_armed = 1'b0;
      ext_trig = 1'b1;
    end
    // Hardware reset hold; a new trigger restarts the full period
    unique case (s_q.st)
      ST_IDLE: begin
        if (por_trig_q || ext_trig) begin
          s_d.st = ST_HOLD;
          s_d.hold_cnt = HOLD_COUNT - 10'h001;
          s_d.hw_rst = 1'b1;
        end
      end
      ST_HOLD: begin
        if (por_trig_q || ext_trig) begin
          s_d.hold_cnt = HOLD_COUNT - 10'h001;
        end else if (s_q.hold_cnt == HOLD_RST) begin
          s_d.st = ST_IDLE;
          s_d.hw_rst = 1'b0;
        end else begin
          s_d.hold_cnt = s_q.hold_cnt - 10'h001;
        end
      end
    endcase
    // Watchdog fires only if enabled and not serviced in the same cycle
    s_d.wd_rst = wdog_enable && wdog_expire && !wdog_serviced;
    s_d.host_rst = host_iface_rst_bit;
    s_d.sw_rst = sw_service_write;
    // Reset matrix
    hw_any = s_q.hw_rst || s_q.wd_rst;
    s_d.core = hw_any || s_q.host_rst;
    s_d.eth = hw_any || s_q.host_rst || s_q.sw_rst;
    s_d.dma = hw_any || s_q.host_rst || s_q.sw_rst;
    s_d.gen = hw_any || s_q.host_rst || s_q.sw_rst;
    s_d.serial_module = hw_any || s_q.host_rst || s_q.sw_rst;
    s_d.hif = hw_any;
    s_d.mem = hw_any;
    s_d.gen_sticky = hw_any;
    s_d.pc4 = s_q.host_rst || s_q.sw_rst;
    // PLL test routing; the clock select is a control, the clock mux itself
    // sits in the analog wrapper, so no clock runs through this logic
    s_d.osc_on = test_lvl;
    s_d.clk_sel = !test_lvl;
    if (!test_lvl) begin
      s_d.indiv = {pa_lvl[PA_INDIV1], pa_lvl[PA_INDIV0]};
      s_d.icp = {pa_lvl[PA_ICP3], pa_lvl[PA_ICP3+1],
                 pa_lvl[PA_ICP0-1], pa_lvl[PA_ICP0]};
      s_d.outdiv = {pa_lvl[PA_OUTDIV1], pa_lvl[PA_OUTDIV0]};
      s_d.poltst = {pa_lvl[PA_POLTST3], pa_lvl[PA_POLTST3-1],
                    pa_lvl[PA_POLTST0+1], pa_lvl[PA_POLTST0]};
      s_d.tst = pa_lvl[PA_TEST];
      s_d.ckr = tck_lvl;
      s_d.ckdiv = td1_lvl;
      s_d.dis = bist_lvl ? 1'b1 : pa_lvl[PA_ENB];
    end else begin
      s_d.indiv = fw_indiv;
      s_d.icp = fw_icp;
      s_d.outdiv = fw_outdiv;
      s_d.poltst = fw_poltst;
      s_d.tst = 1'b0;
      s_d.dis = 1'b0;
      s_d.ckr = 1'b0;
      s_d.ckdiv = 1'b0;
    end
    // Observation drive only in combined test and self-test-on mode
    s_d.obs = obs_lvl;
    s_d.obs_oe = (!test_lvl && !bist_lvl) ? 5'h1f : 5'h00;
  end

  // Everything comes up cleared in reset except the deglitch chain and the oscillator enable
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.dg <= '1;
      s_q.st <= ST_IDLE;
      s_q.hold_cnt <= HOLD_RST;
      s_q.osc_on <= 1'b1;
      s_q.indiv <= PLL_INDIV_RST;
      s_q.icp <= PLL_ICP_RST;
      s_q.outdiv <= PLL_OUTDIV_RST;
      s_q.poltst <= PLL_POLTST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a register bit of the state copy
  assign hw_reset = s_q.hw_rst;
  assign rst_core = s_q.core;
  assign rst_eth_front_end = s_q.eth;
  assign rst_dma = s_q.dma;
  assign rst_general_module = s_q.gen;
  assign rst_serial_module = s_q.serial_module;
  assign rst_embedded_host_iface = s_q.hif;
  assign rst_mem_ctrl = s_q.mem;
  assign rst_general_sticky_fields = s_q.gen_sticky;
  assign port_c_bit4_out = s_q.pc4;
  assign osc_on = s_q.osc_on;
  assign core_clock_sel_osc = s_q.clk_sel;
  assign pll_indiv = s_q.indiv;
  assign pll_icp = s_q.icp;
  assign pll_outdiv = s_q.outdiv;
  assign pll_poltst = s_q.poltst;
  assign pll_disable = s_q.dis;
  assign pll_test = s_q.tst;
  assign pll_ref_clk = s_q.ckr;
  assign pll_fb_clk = s_q.ckdiv;
  assign port_a_obs_out = s_q.obs;
  assign port_a_obs_oe = s_q.obs_oe;
endmodule
`default_nettype wire

/* hdl/rst_pkg.sv */
// Package: constants for the reset generator and PLL test routing
package rst_pkg;
  localparam int POR_CNT_W = 5;
  localparam logic [4:0] POR_CNT_DONE = 5'h1f;
  localparam logic [4:0] POR_CNT_RST = 5'h00;
  localparam int DEGLITCH_STAGES = 6;
  localparam int HOLD_CYCLES = 512;
  localparam int HOLD_W = 10;
  localparam logic [9:0] HOLD_COUNT = 10'h200;
  localparam logic [9:0] HOLD_RST = 10'h000;
  localparam int SYNC_STAGES = 3;
  // Reset values of the PLL register fields, loaded only while rstn is low
  localparam logic [1:0] PLL_INDIV_RST = 2'h0;
  localparam logic [3:0] PLL_ICP_RST = 4'h0;
  localparam logic [1:0] PLL_OUTDIV_RST = 2'h0;
  localparam logic [3:0] PLL_POLTST_RST = 4'h0;
  // Port A pin positions for test routing
  localparam int PA_INDIV1 = 0;
  localparam int PA_INDIV0 = 1;
  localparam int PA_ICP3 = 2;
  localparam int PA_ICP0 = 5;
  localparam int PA_OUTDIV1 = 6;
  localparam int PA_OUTDIV0 = 7;
  localparam int PA_ENB = 8;
  localparam int PA_POLTST0 = 9;
  localparam int PA_POLTST3 = 12;
  localparam int PA_TEST = 13;
  localparam int PA_OBS_LO = 3;
  localparam int PA_OBS_HI = 7;
endpackage

/* hdl/pin_sync.sv */
// Three-stage synchroniser whose output changes when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import rst_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sh;
    logic lvl;
  } sync_t;
  sync_t s_q;
  sync_t s_d;

  // Stage one feeds only stage two; the agree test looks at two and three
  always_comb begin
    s_d = s_q;
    s_d.sh = {s_q.sh[SYNC_STAGES-2:0], pin};
    if (s_q.sh[1] == s_q.sh[2]) begin
      s_d.lvl = s_q.sh[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_q <= {{SYNC_STAGES{RST_VAL}}, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.lvl;
endmodule
`default_nettype wire

/* test/rst_checker.sv */
// Checker: timing and reset-matrix assertions on the reset generator ports
`timescale 1ns/1ps
`default_nettype none
module rst_checker (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic por_pulse,
  input wire logic wdog_enable,
  input wire logic wdog_expire,
  input wire logic wdog_serviced,
  input wire logic host_iface_rst_bit,
  input wire logic sw_service_write,
  input wire logic pll_bypass_test_n,
  input wire logic hw_reset,
  input wire logic rst_core,
  input wire logic rst_general_module,
  input wire logic rst_mem_ctrl,
  input wire logic rst_embedded_host_iface,
  input wire logic port_c_bit4_out,
  input wire logic osc_on,
  input wire logic pll_disable,
  input wire logic pll_test
);
  logic [9:0] hold_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Length of the current hardware reset; a retrigger would need a wider check
  always_ff @(posedge clk_sys) begin
    if (!rstn || !hw_reset) hold_q <= 10'h000;
    else hold_q <= hold_q + 10'h001;
  end
  sequence s_low8;
    (!por_pulse)[*8];
  endsequence
  sequence s_calm;
    s_low8 ##1 s_low8 ##1 s_low8;
  endsequence
  sequence s_bite;
    wdog_enable && wdog_expire && !wdog_serviced;
  endsequence
  AST_POR_COUNT: assert property (
    $fell(por_pulse) ##1 s_calm |-> !hw_reset ##[1:14] hw_reset)
    else $error("power-on count length wrong");
  AST_HOLD_512: assert property ($fell(hw_reset) |-> hold_q == 10'h200)
    else $error("hardware reset length wrong");
  AST_WDOG_HIT: assert property (s_bite |-> ##2 rst_core && rst_mem_ctrl)
    else $error("watchdog reset missing");
  AST_SW_GEN: assert property (sw_service_write |-> ##2 rst_general_module)
    else $error("software reset missing");
  AST_HIF_SRC: assert property ($rose(rst_embedded_host_iface) |->
    $past(hw_reset) || $past(wdog_expire, 2)) else $error("host module reset from wrong source");
  AST_HOST_LVL: assert property (host_iface_rst_bit[*3] |-> rst_core && port_c_bit4_out)
    else $error("host reset level not followed");
  AST_PORTC_SRC: assert property ($rose(port_c_bit4_out) |->
    $past(sw_service_write, 2) || $past(host_iface_rst_bit, 2)) else $error("port C reset source");
  AST_BYPASS_HI: assert property (
    pll_bypass_test_n[*6] |-> osc_on && !pll_disable && !pll_test)
    else $error("normal mode PLL controls wrong");
endmodule
bind reset_gen_and_pll_test_mux rst_checker i_chk (.*);
`default_nettype wire

/* test/rst_far_side.sv */
// Far-side model: external reset circuit, oscillator and PLL tester
`timescale 1ns/1ps
`default_nettype none
module rst_far_side (
  input wire logic clk_sys,
  output logic ext_reset_n,
  output logic pll_bypass_test_n,
  output logic selftest_enable_n,
  output logic osc_input_pin,
  output logic [13:0] port_a_in,
  output logic tck_in,
  output logic td1_in,
  output logic pll_divider_out,
  output logic pll_pump_up,
  output logic pll_lock,
  output logic pll_pump_down,
  output logic pll_clock_out
);
  // Idle: reset pin released, PLL in normal mode, tester lines parked
  initial begin
    {ext_reset_n, pll_bypass_test_n, selftest_enable_n, osc_input_pin} = 4'hf;
    {port_a_in, tck_in, td1_in} = 16'h0000;
    {pll_clock_out, pll_pump_down, pll_lock, pll_pump_up, pll_divider_out} = 5'h00;
  end
  // External TTL oscillator runs free, unrelated to the system clock
  always #7 osc_input_pin = ~osc_input_pin;
  // Reset circuit holds the pin low for n cycles
  task automatic ext_low(input int n);
    ext_reset_n = 1'b0;
    repeat (n) @(posedge clk_sys);
    #1 ext_reset_n = 1'b1;
  endtask
  // Tester selects a mode and presents port A and PLL output levels
  task automatic pll_mode(input logic byp_n, input logic bist_n, input logic [13:0] pa,
    input logic [4:0] obs);
    pll_bypass_test_n = byp_n;
    selftest_enable_n = bist_n;
    port_a_in = pa;
    {tck_in, td1_in} = {pa[3], ~pa[3]};
    {pll_clock_out, pll_pump_down, pll_lock, pll_pump_up, pll_divider_out} = obs;
  endtask
endmodule
`default_nettype wire

/* test/reset_gen_and_pll_test_mux_bench.sv */
// Bench: self-checking run of the reset generator and PLL test routing
`timescale 1ns/1ps
`default_nettype none
module reset_gen_and_pll_test_mux_bench;
  import rst_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, por_pulse = 1'b1;
  logic wdog_enable = 1'b0, wdog_expire = 1'b0, wdog_serviced = 1'b0;
  logic host_iface_rst_bit = 1'b0, sw_service_write = 1'b0;
  logic [1:0] fw_indiv = 2'h2, fw_outdiv = 2'h1, pll_indiv, pll_outdiv;
  logic [3:0] fw_icp = 4'h9, fw_poltst = 4'h6, pll_icp, pll_poltst;
  logic ext_reset_n, pll_bypass_test_n, selftest_enable_n, osc_input_pin, tck_in, td1_in;
  logic pll_divider_out, pll_pump_up, pll_lock, pll_pump_down, pll_clock_out;
  logic [13:0] port_a_in;
  logic hw_reset, rst_core, rst_eth_front_end, rst_dma, rst_general_module, rst_serial_module;
  logic rst_embedded_host_iface, rst_mem_ctrl, rst_general_sticky_fields, port_c_bit4_out;
  logic osc_on, core_clock_sel_osc, pll_disable, pll_test, pll_ref_clk, pll_fb_clk;
  logic [4:0] port_a_obs_out, port_a_obs_oe;
  int miscompares = 0, tests_run = 0, cycles = 0;
  reset_gen_and_pll_test_mux i_dut (.*);
  rst_far_side i_far (.*);
  always #2.5 clk_sys = ~clk_sys;
  // Whole run needs about 1200 cycles; a hang is cut off well beyond that
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  function automatic logic [9:0] mods();
    return {hw_reset, rst_core, rst_eth_front_end, rst_dma, rst_general_module,
      rst_serial_module, rst_embedded_host_iface, rst_mem_ctrl, rst_general_sticky_fields,
      port_c_bit4_out};
  endfunction
  // Wait for a hardware reset, measure its length and the module resets under it
  task automatic hw_pulse(input int lim, output int lat, output int len);
    lat = 0;
    len = 0;
    while (hw_reset !== 1'b1 && lat < lim) begin
      tick(1);
      lat++;
    end
    while (hw_reset === 1'b1 && len < 600) begin
      if (len == 20) begin
        chk("modules", mods(), 32'h3fe);
      end
      tick(1);
      len++;
    end
  endtask
  task automatic t_por();
    int lat, len;
    por_pulse = 1'b0;
    tick(20);
    por_pulse = 1'b1;
    tick(2);
    por_pulse = 1'b0;
    hw_pulse(60, lat, len);
    chk("por_delay", lat >= 31 && lat <= 38, 1);
    chk("por_hold", len, 512);
    $display("power-on test done");
  endtask
  task automatic t_ext();
    int lat, len;
    i_far.ext_low(3);
    hw_pulse(30, lat, len);
    chk("ext_glitch", len, 0);
    i_far.ext_low(10);
    hw_pulse(30, lat, len);
    chk("ext_hold", len, 512);
    $display("external reset test done");
  endtask
  // Rows: {enable, expire, serviced, host bit, service write} and module resets
  task automatic t_src();
    logic [4:0] drv [5] = '{5'h18, 5'h1c, 5'h08, 5'h02, 5'h01};
    logic [9:0] exp [5] = '{10'h1fe, 10'h000, 10'h000, 10'h1f1, 10'h0f1};
    for (int i = 0; i < 5; i++) begin
      {wdog_enable, wdog_expire, wdog_serviced, host_iface_rst_bit, sw_service_write} = drv[i];
      tick(3);
      chk("matrix", mods(), exp[i]);
      {wdog_enable, wdog_expire, wdog_serviced, host_iface_rst_bit, sw_service_write} = 5'h00;
      tick(4);
      chk("release", mods(), 32'h0);
    end
    $display("source matrix test done");
  endtask
  // Modes: test pin low with and without self-test, then test pin high
  task automatic t_pll();
    logic [13:0] pa;
    logic [4:0] ob;
    logic byp;
    logic [14:0] cfg_exp;
    logic [14:0] cfg_seen;
    logic [11:0] obs_exp;
    logic [11:0] obs_seen;
    for (int m = 0; m < 3; m++) begin
      pa = 14'h1a6d ^ 14'(m);
      ob = 5'h13 ^ 5'(m);
      byp = (m == 2);
      i_far.pll_mode(byp, m == 1, pa, ob);
      // Port A order: indiv 1..0, icp 3..0, outdiv 1..0, then poltst from PA12 down
      cfg_exp = {1'b0, pa[0], pa[1], pa[2], pa[3], pa[4], pa[5], pa[6], pa[7], pa[12:9],
        m == 1 || pa[8], pa[13]};
      if (byp) cfg_exp = {1'b1, fw_indiv, fw_icp, fw_outdiv, fw_poltst, 2'h0};
      obs_exp = {tck_in, td1_in, m == 1 ? 10'h000 : {5'h1f, ob}};
      tick(8);
      cfg_seen = {osc_on, pll_indiv, pll_icp, pll_outdiv, pll_poltst, pll_disable, pll_test};
      obs_seen = {pll_ref_clk, pll_fb_clk, port_a_obs_oe, port_a_obs_out & port_a_obs_oe};
      chk("pll_cfg", cfg_seen, cfg_exp);
      chk("clk_sel", core_clock_sel_osc, !byp);
      if (!byp) chk("pll_obs", obs_seen, obs_exp);
    end
    $display("pll test mode test done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Reset for three cycles with the power-on pulse still present
  initial begin
    tick(3);
    rstn = 1'b1;
    tick(8);
    t_por();
    t_ext();
    t_src();
    t_pll();
    tally_and_finish();
  end
endmodule
`default_nettype wire
